// >>> verilog/ela_consts.svh
// register map, field positions and sizes of the capture core
`ifndef ELA_CONSTS_SVH
`define ELA_CONSTS_SVH

`define ELA_ADDR_W      12
`define ELA_DATA_W      32
`define ELA_WORD_SH     2
`define ELA_TRIG_W      32
`define ELA_NUM_TRIG    3
`define ELA_QUARTER_SH  2

// register byte offsets
`define ELA_OFF_CTRL    12'h000
`define ELA_OFF_STATUS  12'h004
`define ELA_OFF_REQ_DEP 12'h008
`define ELA_OFF_DEPTH   12'h00C
`define ELA_OFF_REC_LEN 12'h010
`define ELA_OFF_RD_IDX  12'h014
`define ELA_OFF_MARKER  12'h018
`define ELA_OFF_TRIG    12'h020
`define ELA_TRIG_WORDS  12
`define ELA_OFF_STIM    12'h100
`define ELA_OFF_MON     12'h200

// control word fields
`define ELA_CTRL_ARM    0
`define ELA_CTRL_IMM    1
`define ELA_CTRL_PRE    2
`define ELA_CTRL_NTRIG  4

// status word fields
`define ELA_STAT_ARMED  0
`define ELA_STAT_TRIG   1
`define ELA_STAT_DONE   2
`define ELA_STAT_WARN   3
`define ELA_STAT_STIMV  4

// per-trigger word fields, four words a trigger
`define ELA_TFLD_LEVEL  2'h0
`define ELA_TFLD_CARE   2'h1
`define ELA_TFLD_EDGE   2'h2
`define ELA_TFLD_MODE   2'h3

`endif

// >>> verilog/ela_pkg.sv
// types shared by the capture core modules
`include "ela_consts.svh"

package ela_pkg;

  typedef enum logic [1:0] {
    CAP_IDLE,
    CAP_ARMED,
    CAP_POST,
    CAP_DONE
  } cap_state_t;

  typedef struct packed {
    logic [`ELA_TRIG_W-1:0] level;
    logic [`ELA_TRIG_W-1:0] care;
    logic [`ELA_TRIG_W-1:0] edge_m;
    logic                   use_or;
  } trig_cfg_t;

  typedef struct packed {
    logic                   sel;
    logic                   enable;
    logic                   write;
    logic [`ELA_ADDR_W-1:0] addr;
    logic [`ELA_DATA_W-1:0] wdata;
  } apb_req_t;

endpackage

// >>> verilog/ela_trigger.sv
// sequential trigger evaluator, up to three patterns in order
`timescale 1ns/1ps
`default_nettype none

module ela_trigger
  import ela_pkg::*;
(
  // clock and control
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic                            ce,
  input  wire logic                            restart,
  input  wire logic                            run,
  input  wire logic                            immediate,
  // pattern setup
  input  wire trig_cfg_t [`ELA_NUM_TRIG-1:0]   cfg,
  input  wire logic [1:0]                      count,
  // observed channels
  input  wire logic [`ELA_TRIG_W-1:0]          chan,
  output logic                                 fire
);

  typedef struct packed {
    logic [`ELA_TRIG_W-1:0] prev;
    logic [1:0]             stage;
  } trig_state_t;

  trig_state_t q;
  trig_state_t d;
  logic [1:0]  last_stage;

  function automatic logic match(input trig_cfg_t c,
                                 input logic [`ELA_TRIG_W-1:0] cur,
                                 input logic [`ELA_TRIG_W-1:0] old);
    logic [`ELA_TRIG_W-1:0] hit;
    hit = (c.edge_m & ((c.level & cur & ~old) | (~c.level & ~cur & old)))
        | (~c.edge_m & ~(cur ^ c.level));
    // an all don't-care pattern matches on its first evaluated cycle
    if (c.care == '0)
      match = 1'b1;
    else if (c.use_or)
      match = |(hit & c.care);
    else
      match = &(hit | ~c.care);
  endfunction

  always_comb begin
    d          = q;
    d.prev     = chan;
    fire       = 1'b0;
    last_stage = (count == 2'h0) ? 2'h0 : count - 2'h1;
    if (restart) begin
      d.stage = '0;
    end else if (run) begin
      if (immediate) begin
        fire = 1'b1;
      end else if (match(cfg[q.stage], chan, q.prev)) begin
        // a later stage is only looked at from the next cycle on
        if (q.stage >= last_stage) begin
          fire = 1'b1;
        end else begin
          d.stage = q.stage + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= trig_state_t'('0);
    end else if (ce) begin
      q <= d;
    end
  end

endmodule // ela_trigger

`default_nettype wire

// >>> verilog/ela_trace_buf.sv
// trace buffer held in flip-flops, one write and one read port
`timescale 1ns/1ps
`default_nettype none

module ela_trace_buf #(
  parameter int W     = 32,
  parameter int DEPTH = 1024,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock and control
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  // read side
  input  wire logic [AW-1:0] rd_addr,
  output logic [W-1:0]       rd_data
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
  } buf_state_t;

  buf_state_t q;
  buf_state_t d;

  always_comb begin
    d = q;
    if (wr_en) begin
      d.mem[wr_addr] = wr_data;
    end
  end

  assign rd_data = q.mem[rd_addr];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= buf_state_t'('0);
    end else if (ce) begin
      q <= d;
    end
  end

endmodule // ela_trace_buf

`default_nettype wire

// >>> verilog/ela_capture.sv
// logic analyzer capture core with stimulus output and apb registers
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module ela_capture
  import ela_pkg::*;
#(
  parameter int MON_W  = 32,
  parameter int DEPTH  = 1024,
  parameter int STIM_W = 8
) (
  // clock, reset and enable
  input  wire logic                     CLOCK,
  input  wire logic                     RESET_N,
  input  wire logic                     CLK_EN,
  // apb slave
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [`ELA_ADDR_W-1:0]   PADDR,
  input  wire logic [`ELA_DATA_W-1:0]   PWDATA,
  output logic [`ELA_DATA_W-1:0]        PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR,
  // design under test
  input  wire logic [MON_W-1:0]         MONITOR,
  input  wire logic [`ELA_TRIG_W-1:0]   TRIGGER,
  output logic [(STIM_W==0?1:STIM_W)-1:0] STIMULUS,
  output logic                          STIMULUS_VALID
);

  localparam int DW         = `ELA_DATA_W;
  localparam int AW         = $clog2(DEPTH);
  localparam int MON_WORDS  = (MON_W + DW - 1) / DW;
  localparam int STIM_WORDS = (STIM_W == 0) ? 1 : (STIM_W + DW - 1) / DW;
  localparam int MON_P      = MON_WORDS * DW;
  localparam int STIM_P     = STIM_WORDS * DW;
  localparam int STIM_O     = (STIM_W == 0) ? 1 : STIM_W;

  typedef struct packed {
    cap_state_t                     st;
    logic                           immediate;
    logic [1:0]                     pre_code;
    logic [1:0]                     ntrig;
    trig_cfg_t [`ELA_NUM_TRIG-1:0]  trig;
    logic [DW-1:0]                  req_depth;
    logic [AW-1:0]                  rd_index;
    logic [STIM_P-1:0]              stim;
    logic [STIM_P-1:0]              stim_out;
    logic                           stim_valid;
    logic [AW-1:0]                  wr_ptr;
    logic [AW:0]                    pre_cnt;
    logic [AW:0]                    post_cnt;
    logic [AW-1:0]                  trig_ptr;
    logic [AW:0]                    pre_have;
    logic                           triggered;
    logic                           ack;
    logic                           err;
    logic [DW-1:0]                  rdata;
  } core_t;

  core_t               q;
  core_t               d;
  apb_req_t            req;
  logic                fire;
  logic                arm_now;
  logic                buf_we;
  logic [MON_W-1:0]    rd_sample;
  logic [MON_P-1:0]    rd_pad;
  logic [AW-1:0]       rd_addr;
  logic [AW:0]         quarter;
  logic [AW:0]         pre_n;
  logic [AW:0]         post_n;
  logic [AW:0]         rec_len;
  logic                marker;
  logic                warn;
  logic [DW-1:0]       rv;
  logic                mapped;
  int                  widx;

  function automatic logic in_win(input logic [`ELA_ADDR_W-1:0] a,
                                  input logic [`ELA_ADDR_W-1:0] base,
                                  input int words);
    in_win = (a >= base) && (a[1:0] == 2'h0)
          && (int'((a - base) >> `ELA_WORD_SH) < words);
  endfunction

  function automatic int word_of(input logic [`ELA_ADDR_W-1:0] a,
                                 input logic [`ELA_ADDR_W-1:0] base);
    word_of = int'((a - base) >> `ELA_WORD_SH);
  endfunction

  assign req.sel    = PSEL;
  assign req.enable = PENABLE;
  assign req.write  = PWRITE;
  assign req.addr   = PADDR;
  assign req.wdata  = PWDATA;

  // pre-store length is a quarter step of the built-in depth
  assign quarter = (AW+1)'(DEPTH >> `ELA_QUARTER_SH);
  assign pre_n   = (AW+1)'(quarter * {{(AW-1){1'b0}}, q.pre_code});
  assign post_n  = (AW+1)'(DEPTH) - pre_n;

  // nonzero request that does not equal the built-in depth is only flagged
  assign warn = (q.req_depth != '0) && (q.req_depth != DW'(DEPTH));

  assign rec_len = (q.st == CAP_DONE) ? (q.pre_have + post_n) : '0;
  // readout index 0 is the oldest sample of the record
  assign rd_addr = q.trig_ptr - q.pre_have[AW-1:0] + q.rd_index;
  assign rd_pad  = MON_P'(rd_sample);
  assign marker  = (q.pre_code != 2'h0)
                && ({1'b0, q.rd_index} < q.pre_have);

  assign arm_now = req.sel && req.enable && q.ack && req.write
                && (req.addr == `ELA_OFF_CTRL)
                && req.wdata[`ELA_CTRL_ARM];

  ela_trigger u_trigger (
    .clk       (CLOCK),
    .rst_n     (RESET_N),
    .ce        (CLK_EN),
    .restart   (arm_now),
    .run       (q.st == CAP_ARMED),
    .immediate (q.immediate),
    .cfg       (q.trig),
    .count     (q.ntrig),
    .chan      (TRIGGER),
    .fire      (fire)
  );

  ela_trace_buf #(
    .W     (MON_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_buf (
    .clk     (CLOCK),
    .rst_n   (RESET_N),
    .ce      (CLK_EN),
    .wr_en   (buf_we),
    .wr_addr (q.wr_ptr),
    .wr_data (MONITOR),
    .rd_addr (rd_addr),
    .rd_data (rd_sample)
  );

  // register read mux, also tells which addresses exist
  always_comb begin
    rv     = '0;
    mapped = 1'b1;
    widx   = 0;
    case (req.addr)
      `ELA_OFF_CTRL: begin
        rv[`ELA_CTRL_IMM]     = q.immediate;
        rv[`ELA_CTRL_PRE +: 2]   = q.pre_code;
        rv[`ELA_CTRL_NTRIG +: 2] = q.ntrig;
      end
      `ELA_OFF_STATUS: begin
        rv[`ELA_STAT_ARMED] = (q.st == CAP_ARMED) || (q.st == CAP_POST);
        rv[`ELA_STAT_TRIG]  = q.triggered;
        rv[`ELA_STAT_DONE]  = (q.st == CAP_DONE);
        rv[`ELA_STAT_WARN]  = warn;
        rv[`ELA_STAT_STIMV] = q.stim_valid;
      end
      `ELA_OFF_REQ_DEP: rv = q.req_depth;
      `ELA_OFF_DEPTH:   rv = DW'(DEPTH);
      `ELA_OFF_REC_LEN: rv = DW'(rec_len);
      `ELA_OFF_RD_IDX:  rv = DW'(q.rd_index);
      `ELA_OFF_MARKER:  rv = DW'(marker);
      default: begin
        if (in_win(req.addr, `ELA_OFF_TRIG, `ELA_TRIG_WORDS)) begin
          widx = word_of(req.addr, `ELA_OFF_TRIG);
          case (widx[1:0])
            `ELA_TFLD_LEVEL: rv = q.trig[widx >> 2].level;
            `ELA_TFLD_CARE:  rv = q.trig[widx >> 2].care;
            `ELA_TFLD_EDGE:  rv = q.trig[widx >> 2].edge_m;
            default:         rv = DW'(q.trig[widx >> 2].use_or);
          endcase
        end else if (in_win(req.addr, `ELA_OFF_STIM, STIM_WORDS)) begin
          widx = word_of(req.addr, `ELA_OFF_STIM);
          rv   = q.stim[widx*DW +: DW];
        end else if (in_win(req.addr, `ELA_OFF_MON, MON_WORDS)) begin
          widx = word_of(req.addr, `ELA_OFF_MON);
          rv   = rd_pad[widx*DW +: DW];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  // next state: capture engine, then bus writes, arming last
  always_comb begin
    d            = q;
    buf_we       = 1'b0;
    d.stim_valid = 1'b0;

    case (q.st)
      CAP_ARMED: begin
        buf_we   = 1'b1;
        d.wr_ptr = q.wr_ptr + AW'(1);
        if (fire) begin
          d.triggered = 1'b1;
          d.trig_ptr  = q.wr_ptr;
          d.pre_have  = q.pre_cnt;
          if (post_n == (AW+1)'(1)) begin
            d.st = CAP_DONE;
          end else begin
            d.post_cnt = (AW+1)'(1);
            d.st       = CAP_POST;
          end
        end else if (q.pre_cnt < pre_n) begin
          // older samples beyond the pre-store length are overwritten
          d.pre_cnt = q.pre_cnt + (AW+1)'(1);
        end
      end
      CAP_POST: begin
        buf_we   = 1'b1;
        d.wr_ptr = q.wr_ptr + AW'(1);
        if (q.post_cnt + (AW+1)'(1) == post_n) begin
          d.st = CAP_DONE;
        end else begin
          d.post_cnt = q.post_cnt + (AW+1)'(1);
        end
      end
      CAP_IDLE: begin
      end
      CAP_DONE: begin
      end
      default: begin
        d.st = CAP_IDLE;
      end
    endcase

    // one wait state: ready rises a cycle after enable, with read data latched on the same edge
    if (req.sel && req.enable && !q.ack) begin
      d.ack   = 1'b1;
      d.rdata = rv;
      d.err   = !mapped;
    end else if (req.sel && req.enable && q.ack) begin
      d.ack = 1'b0;
      d.err = 1'b0;
      if (req.write && mapped) begin
        case (req.addr)
          `ELA_OFF_CTRL: begin
            d.immediate = req.wdata[`ELA_CTRL_IMM];
            d.pre_code  = req.wdata[`ELA_CTRL_PRE +: 2];
            d.ntrig     = req.wdata[`ELA_CTRL_NTRIG +: 2];
          end
          `ELA_OFF_REQ_DEP: d.req_depth = req.wdata;
          `ELA_OFF_RD_IDX:  d.rd_index  = req.wdata[AW-1:0];
          default: begin
            if (in_win(req.addr, `ELA_OFF_TRIG, `ELA_TRIG_WORDS)) begin
              case (widx[1:0])
                `ELA_TFLD_LEVEL: d.trig[widx >> 2].level  = req.wdata;
                `ELA_TFLD_CARE:  d.trig[widx >> 2].care   = req.wdata;
                `ELA_TFLD_EDGE:  d.trig[widx >> 2].edge_m = req.wdata;
                default:         d.trig[widx >> 2].use_or = req.wdata[0];
              endcase
            end else if (in_win(req.addr, `ELA_OFF_STIM, STIM_WORDS)) begin
              d.stim[widx*DW +: DW] = req.wdata;
            end
          end
        endcase
      end
    end else begin
      d.ack = 1'b0;
      d.err = 1'b0;
    end

    // arming restarts the record and fires the stimulus once
    if (arm_now) begin
      d.st         = CAP_ARMED;
      d.wr_ptr     = '0;
      d.pre_cnt    = '0;
      d.post_cnt   = '0;
      d.pre_have   = '0;
      d.triggered  = 1'b0;
      d.stim_out   = q.stim;
      d.stim_valid = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      q <= core_t'('0);
    end else if (CLK_EN) begin
      q <= d;
    end
  end

  assign PRDATA  = q.rdata;
  assign PREADY  = q.ack;
  assign PSLVERR = q.err;

  // bus holds still between sessions, so an open output is harmless
  assign STIMULUS = (STIM_W == 0) ? '0 : q.stim_out[STIM_O-1:0];
  // sink must qualify the bus with this strobe
  assign STIMULUS_VALID = q.stim_valid;

endmodule // ela_capture

`default_nettype wire

// >>> tb/ela_capture_props.sv
// port-level assertions for the capture core, bound into ela_capture
`timescale 1ns/1ps
`default_nettype none
`include "ela_consts.svh"

module ela_capture_props #(
  parameter int STIM_W = 8
) (
  // clock and reset
  input wire logic                         CLOCK,
  input wire logic                         RESET_N,
  input wire logic                         CLK_EN,
  // apb
  input wire logic                         PSEL,
  input wire logic                         PENABLE,
  input wire logic                         PWRITE,
  input wire logic [`ELA_ADDR_W-1:0]       PADDR,
  input wire logic [`ELA_DATA_W-1:0]       PWDATA,
  input wire logic [`ELA_DATA_W-1:0]       PRDATA,
  input wire logic                         PREADY,
  input wire logic                         PSLVERR,
  // stimulus
  input wire logic [(STIM_W==0?1:STIM_W)-1:0] STIMULUS,
  input wire logic                         STIMULUS_VALID
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  wire logic arm_w;
  assign arm_w = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR &&
                 PADDR == `ELA_OFF_CTRL && PWDATA[`ELA_CTRL_ARM];

  chk_ready_once: assert property (PREADY && CLK_EN |=> !PREADY)
    else $error("ready held longer than one cycle");
  chk_ready_wait: assert property (PSEL && !PENABLE && CLK_EN ##1
    PSEL && PENABLE && CLK_EN |=> PREADY)
    else $error("ready not one cycle after access");
  chk_ready_idle: assert property (!PSEL |-> !PREADY)
    else $error("ready without select");
  chk_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  chk_err_data: assert property (PSLVERR |-> PRDATA == '0)
    else $error("error read data not zero");
  chk_err_align: assert property (PREADY && PADDR[1:0] != 2'h0 |->
    PSLVERR)
    else $error("misaligned access not refused");
  chk_valid_pulse: assert property (STIMULUS_VALID |=> !STIMULUS_VALID)
    else $error("stimulus strobe longer than one cycle");
  chk_valid_cause: assert property (STIMULUS_VALID |->
    $past(arm_w, 1) || $past(arm_w, 2))
    else $error("stimulus strobe without arm");
  chk_stim_load: assert property (!$stable(STIMULUS) |->
    ##[0:1] STIMULUS_VALID)
    else $error("stimulus changed outside arm");

  cov_arm: cover property (arm_w);
  cov_err: cover property (PSLVERR);
  cov_strobe: cover property (STIMULUS_VALID);
endmodule // ela_capture_props

bind ela_capture ela_capture_props #(.STIM_W(STIM_W)) u_props (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .CLK_EN(CLK_EN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .STIMULUS(STIMULUS), .STIMULUS_VALID(STIMULUS_VALID));
`default_nettype wire

// >>> tb/dut_side_model.sv
// far-side model: same-clock user logic feeding monitor and trigger lines
`timescale 1ns/1ps
`default_nettype none

module dut_side_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // from the capture core
  input  wire logic [7:0]  stim,
  input  wire logic        stim_v,
  // to the capture core, and to the bench the last stimulus received
  output logic [31:0]      mon,
  output logic [31:0]      trig,
  output logic [7:0]       got
);
  logic [31:0] cnt_q;
  // a free counter makes every sample predictable from the trigger value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      got   <= '0;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
      if (stim_v) begin
        got <= stim;
      end
    end
  end
  assign mon  = cnt_q;
  assign trig = cnt_q;
endmodule // dut_side_model
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the capture core
`timescale 1ns/1ps
`default_nettype none
`include "ela_consts.svh"

module tb;
  import ela_pkg::*;
  localparam int DEPTH = 16;
  logic        CLOCK = 0, RESET_N = 0, psel = 0, pen = 0, pwr = 0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rd, rd0;
  wire  [31:0] prdata, prdata0, mon, trig;
  wire  [7:0]  stim, got;
  wire         pready, pslverr, sv;
  int          bad_count = 0, checks_done = 0, vcnt = 0;

  always #50 CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (sv === 1'b1) vcnt <= vcnt + 1;

  ela_capture #(.MON_W(32), .DEPTH(DEPTH), .STIM_W(8)) dut (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .CLK_EN(1'b1), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .MONITOR(mon),
    .TRIGGER(trig), .STIMULUS(stim), .STIMULUS_VALID(sv));
  // pure capture copy: no stimulus bus, follows the same register traffic
  ela_capture #(.MON_W(32), .DEPTH(DEPTH), .STIM_W(0)) dut_bare (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .CLK_EN(1'b1), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata0), .PREADY(), .PSLVERR(), .MONITOR(mon),
    .TRIGGER(trig), .STIMULUS(), .STIMULUS_VALID());
  dut_side_model pm (.clk(CLOCK), .rst_n(RESET_N), .stim(stim),
    .stim_v(sv), .mon(mon), .trig(trig), .got(got));

  task automatic tally_and_finish();
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // pready is read at the rising edge before the edge's updates land
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge CLOCK);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge CLOCK);
    pen <= 1;
    do begin
      @(posedge CLOCK);
    end while (pready !== 1'b1);
    rd = prdata;
    rd0 = prdata0;
    err = pslverr;
    psel <= 0; pen <= 0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, '0);
    cmp(rd, e);
    cmp(rd0, e);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(0, `ELA_OFF_STATUS, '0);
      n++;
    end while (rd[`ELA_STAT_DONE] !== 1'b1 && n < 200);
    cmp(rd[`ELA_STAT_DONE], 1);
  endtask

  task automatic t_regs();
    rdc(`ELA_OFF_STATUS, 32'h0000_0000);
    rdc(`ELA_OFF_DEPTH, DEPTH);
    apb(0, 12'h0FC, '0);
    cmp({err, rd}, {1'b1, 32'h0000_0000});
    apb(1, 12'h002, 32'hFFFF_FFFF);
    cmp(err, 1);
  endtask
  task automatic t_warn();
    apb(1, `ELA_OFF_REQ_DEP, 32'h0000_0008);
    rdc(`ELA_OFF_STATUS, 32'h0000_0008);
  endtask
  task automatic t_stim(input logic [7:0] v, input int pulses);
    apb(1, `ELA_OFF_STIM, {24'h00_0000, v});
    apb(1, `ELA_OFF_CTRL, 32'h0000_0001);
    repeat (40) @(posedge CLOCK);
    cmp(vcnt, pulses);
    cmp(got, v);
    wait_done();
  endtask
  task automatic t_pre(input int code);
    logic [31:0] tgt;
    int pre;
    pre = code * DEPTH / 4;
    tgt = pm.cnt_q + 32'h0000_003C;
    apb(1, `ELA_OFF_TRIG, tgt);
    apb(1, `ELA_OFF_TRIG + 12'h004, 32'hFFFF_FFFF);
    apb(1, `ELA_OFF_CTRL, (code << 2) | 1);
    wait_done();
    rdc(`ELA_OFF_REC_LEN, DEPTH);
    for (int i = 0; i < DEPTH; i++) begin
      apb(1, `ELA_OFF_RD_IDX, i);
      rdc(`ELA_OFF_MON, tgt - pre + i);
      rdc(`ELA_OFF_MARKER, (code != 0 && i < pre));
    end
  endtask
  // stage two's nibble comes round before stage one fires, and must not count
  task automatic t_seq();
    logic [31:0] a;
    a = pm.cnt_q + 32'h0000_0050;
    apb(1, `ELA_OFF_TRIG, a);
    apb(1, `ELA_OFF_TRIG + 12'h010, (a - 1) & 32'h0000_000F);
    apb(1, `ELA_OFF_TRIG + 12'h014, 32'h0000_000F);
    apb(1, `ELA_OFF_TRIG + 12'h020, (a + 1) & 32'h0000_000F);
    apb(1, `ELA_OFF_TRIG + 12'h024, 32'h0000_000F);
    apb(1, `ELA_OFF_CTRL, 32'h0000_0031);
    wait_done();
    apb(1, `ELA_OFF_RD_IDX, '0);
    rdc(`ELA_OFF_MON, a + 17);
  endtask

  initial begin
    #(20_000 * 100);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge CLOCK);
    RESET_N <= 1;
    @(posedge CLOCK);
    t_regs();
    t_warn();
    t_stim(8'hA5, 1);
    t_stim(8'h5A, 2);
    for (int c = 0; c < 4; c++) t_pre(c);
    t_seq();
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
